// >>> verilog/usr_params.svh
// constants for the eight-bit universal shift register block
// assumes inclusion by bare name from the package and the top module
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

// storage word
`define USR_WORD_BITS       8
`define USR_WORD_RESET      8'h00

// register byte offsets on the lite bus
`define USR_ADDR_BITS       4
`define USR_OFF_CTRL        4'h0
`define USR_OFF_STATUS      4'h4
`define USR_OFF_EDGES       4'h8

// control register fields
`define USR_CTRL_CLEAR_BIT  0
`define USR_CTRL_COUNT_BIT  1
`define USR_CTRL_COUNT_RST  1'b1

// status register fields
`define USR_STAT_WORD_LSB   0
`define USR_STAT_MODE_LSB   8
`define USR_STAT_DRIVE_BIT  10
`define USR_STAT_PEND_BIT   11

// bus responses
`define USR_RESP_OKAY       2'h0
`define USR_RESP_SLVERR     2'h2

`endif

// >>> verilog/usr_pkg.sv
// types shared by the universal shift register block
// assumes usr_params.svh is on the include path
`include "usr_params.svh"

package usr_pkg;

    // operating mode as {select hi, select lo}
    typedef enum logic [1:0] {
        USR_MODE_HOLD  = 2'h0,
        USR_MODE_RIGHT = 2'h1,
        USR_MODE_LEFT  = 2'h2,
        USR_MODE_LOAD  = 2'h3
    } usr_mode_t;

    // all pin-level inputs, sampled together through one synchroniser
    typedef struct packed {
        logic                        shift_clock;
        logic                        sync_clear_n;
        logic                        mode_select_hi;
        logic                        mode_select_lo;
        logic                        right_shift_serial_in;
        logic                        left_shift_serial_in;
        logic                        bus_drive_en_a_n;
        logic                        bus_drive_en_b_n;
        logic [`USR_WORD_BITS-1:0]   pins;
    } usr_pins_t;

    // lite bus write side states
    typedef enum logic [1:0] {
        USR_WR_COLLECT = 2'b01,
        USR_WR_RESP    = 2'b10
    } usr_wr_state_t;

    // lite bus read side states
    typedef enum logic [1:0] {
        USR_RD_ADDR = 2'b01,
        USR_RD_DATA = 2'b10
    } usr_rd_state_t;

endpackage

// >>> verilog/usr_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes the inputs are slow levels; multi-bit skew is settled by the caller
`timescale 1ns/1ps
`default_nettype none

module usr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second; resets high so active-low pins read idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '1;
            dout    <= '1;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/usr_shift_top.sv
// eight-bit universal shift/storage register with shared parallel pins
// assumes pin inputs are asynchronous to clk and that the board resolves
// the shared pins from pins_out and pins_oe; lite bus runs on clk
//
// Function
// - eight edge-triggered stages form one word
// - state changes only on shift clock rising
// - low clear at edge zeroes all, beats selects
// - both selects high loads pins into stages
// - right shift, serial in enters stage zero
// - left shift, serial in enters stage seven
// - both selects low keeps stored word
// - each stage drives its own shared pin
// - either enable high floats all pins
// - floated pins never stop register operations
// - load mode floats pins regardless of enables
// - end stages drive ungated serial outputs
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usr_params.svh"

module usr_shift_top
    import usr_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    // pins facing the board
    input  wire logic                       shift_clock,
    input  wire logic                       sync_clear_n,
    input  wire logic                       mode_select_hi,
    input  wire logic                       mode_select_lo,
    input  wire logic                       right_shift_serial_in,
    input  wire logic                       left_shift_serial_in,
    input  wire logic                       bus_drive_en_a_n,
    input  wire logic                       bus_drive_en_b_n,
    input  wire logic [`USR_WORD_BITS-1:0]  shared_parallel_pins_in,
    output logic      [`USR_WORD_BITS-1:0]  shared_parallel_pins_out,
    output logic      [`USR_WORD_BITS-1:0]  shared_parallel_pins_oe,
    output logic                            first_stage_serial_out,
    output logic                            last_stage_serial_out,
    // lite bus slave
    input  wire logic [`USR_ADDR_BITS-1:0]  s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic      [1:0]                 s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [`USR_ADDR_BITS-1:0]  s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);

    localparam int W = `USR_WORD_BITS;

    usr_pins_t                 pins_raw;
    usr_pins_t                 pins_s;
    usr_mode_t                 mode;
    logic                      clk_prev_ff;
    logic                      shift_edge;
    logic [W-1:0]              word_ff;
    logic [W-1:0]              nxt_word;
    logic [W-1:0]              drive_ff;
    logic                      clear_pend_ff;
    logic                      count_en_ff;
    logic [31:0]               edges_ff;
    usr_wr_state_t             wr_state_ff;
    usr_rd_state_t             rd_state_ff;
    logic                      aw_have_ff;
    logic                      w_have_ff;
    logic [`USR_ADDR_BITS-1:0] waddr_ff;
    logic [31:0]               wdata_ff;
    logic                      wstrb0_ff;
    logic                      do_write;
    logic                      wr_hit_ctrl;
    logic                      wr_hit_edges;
    logic                      wr_mapped;
    logic                      sw_clear;
    logic [31:0]               rd_value;
    logic                      rd_mapped;

    // bundle every pin so that all of them see the same two-stage delay;
    // data and clock then line up at the detected edge
    assign pins_raw = '{
        shift_clock:           shift_clock,
        sync_clear_n:          sync_clear_n,
        mode_select_hi:        mode_select_hi,
        mode_select_lo:        mode_select_lo,
        right_shift_serial_in: right_shift_serial_in,
        left_shift_serial_in:  left_shift_serial_in,
        bus_drive_en_a_n:      bus_drive_en_a_n,
        bus_drive_en_b_n:      bus_drive_en_b_n,
        pins:                  shared_parallel_pins_in
    };

    usr_sync #(
        .WIDTH ($bits(usr_pins_t))
    ) u_pin_sync (
        .clk   (clk),
        .rst   (rst),
        .din   (pins_raw),
        .dout  (pins_s)
    );

    assign mode = usr_mode_t'({pins_s.mode_select_hi, pins_s.mode_select_lo});

    // rising edge of the synchronised shift clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_prev_ff <= 1'b1;  // matches the synchroniser reset: no false edge
        end else begin
            clk_prev_ff <= pins_s.shift_clock;
        end
    end

    assign shift_edge = pins_s.shift_clock & ~clk_prev_ff;

    // next word for one shift clock edge
    always_comb begin
        nxt_word = word_ff;
        if (!pins_s.sync_clear_n || clear_pend_ff) begin
            nxt_word = `USR_WORD_RESET;
        end else begin
            unique case (mode)
                USR_MODE_HOLD:  nxt_word = word_ff;
                USR_MODE_RIGHT: nxt_word = {word_ff[W-2:0], pins_s.right_shift_serial_in};
                USR_MODE_LEFT:  nxt_word = {pins_s.left_shift_serial_in, word_ff[W-1:1]};
                USR_MODE_LOAD:  nxt_word = pins_s.pins;
            endcase
        end
    end

    // storage stages; drive enables play no part here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_ff <= `USR_WORD_RESET;
        end else if (shift_edge) begin
            word_ff <= nxt_word;
        end
    end

    // pin drivers: per-stage enable, dropped on either enable or load
    for (genvar gi = 0; gi < W; gi++) begin : g_drive
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                drive_ff[gi] <= 1'b0;
            end else begin
                drive_ff[gi] <= ~pins_s.bus_drive_en_a_n & ~pins_s.bus_drive_en_b_n
                                & (mode != USR_MODE_LOAD);
            end
        end
    end

    assign shared_parallel_pins_out = word_ff;
    assign shared_parallel_pins_oe  = drive_ff;
    // serial ends bypass the drive enables for cascading
    assign first_stage_serial_out   = word_ff[0];
    assign last_stage_serial_out    = word_ff[W-1];

    // software clear waits for the next shift edge; a new request wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clear_pend_ff <= 1'b0;
        end else if (sw_clear) begin
            clear_pend_ff <= 1'b1;
        end else if (shift_edge) begin
            clear_pend_ff <= 1'b0;
        end
    end

    // edge counter; a write to it zeroes it and wins over a count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edges_ff <= 32'h0;
        end else if (do_write && wr_hit_edges) begin
            edges_ff <= 32'h0;
        end else if (shift_edge && count_en_ff) begin
            edges_ff <= edges_ff + 32'h1;
        end
    end

    // control bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_en_ff <= `USR_CTRL_COUNT_RST;
        end else if (do_write && wr_hit_ctrl && wstrb0_ff) begin
            count_en_ff <= wdata_ff[`USR_CTRL_COUNT_BIT];
        end
    end

    assign wr_hit_ctrl  = (waddr_ff == `USR_OFF_CTRL);
    assign wr_hit_edges = (waddr_ff == `USR_OFF_EDGES);
    assign wr_mapped    = wr_hit_ctrl | wr_hit_edges | (waddr_ff == `USR_OFF_STATUS);
    assign do_write     = (wr_state_ff == USR_WR_COLLECT) & aw_have_ff & w_have_ff;
    assign sw_clear     = do_write & wr_hit_ctrl & wstrb0_ff
                          & wdata_ff[`USR_CTRL_CLEAR_BIT];

    // write side: address and data in either order, then one response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_state_ff   <= USR_WR_COLLECT;
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            waddr_ff      <= '0;
            wdata_ff      <= 32'h0;
            wstrb0_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `USR_RESP_OKAY;
        end else begin
            unique case (wr_state_ff)
                USR_WR_COLLECT: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_have_ff    <= 1'b1;
                        waddr_ff      <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end else begin
                        s_axi_awready <= ~aw_have_ff;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_have_ff    <= 1'b1;
                        wdata_ff     <= s_axi_wdata;
                        wstrb0_ff    <= s_axi_wstrb[0];
                        s_axi_wready <= 1'b0;
                    end else begin
                        s_axi_wready <= ~w_have_ff;
                    end
                    if (do_write) begin
                        // status is read-only; writes to it are accepted and dropped
                        s_axi_bvalid  <= 1'b1;
                        s_axi_bresp   <= wr_mapped ? `USR_RESP_OKAY : `USR_RESP_SLVERR;
                        s_axi_awready <= 1'b0;
                        s_axi_wready  <= 1'b0;
                        wr_state_ff   <= USR_WR_RESP;
                    end
                end
                USR_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        aw_have_ff    <= 1'b0;
                        w_have_ff     <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        wr_state_ff   <= USR_WR_COLLECT;
                    end
                end
            endcase
        end
    end

    // read decode
    always_comb begin
        rd_value  = 32'h0;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            `USR_OFF_CTRL: begin
                rd_value[`USR_CTRL_COUNT_BIT] = count_en_ff;
            end
            `USR_OFF_STATUS: begin
                rd_value[`USR_STAT_WORD_LSB +: W] = word_ff;
                rd_value[`USR_STAT_MODE_LSB +: 2] = mode;
                rd_value[`USR_STAT_DRIVE_BIT]     = drive_ff[0];
                rd_value[`USR_STAT_PEND_BIT]      = clear_pend_ff;
            end
            `USR_OFF_EDGES: begin
                rd_value = edges_ff;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // read side: data is snapped at the address handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_state_ff   <= USR_RD_ADDR;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `USR_RESP_OKAY;
        end else begin
            unique case (rd_state_ff)
                USR_RD_ADDR: begin
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= rd_value;
                        s_axi_rresp   <= rd_mapped ? `USR_RESP_OKAY : `USR_RESP_SLVERR;
                        rd_state_ff   <= USR_RD_DATA;
                    end else begin
                        s_axi_arready <= 1'b1;
                    end
                end
                USR_RD_DATA: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state_ff   <= USR_RD_ADDR;
                    end
                end
            endcase
        end
    end

    // checks on the stored word
    a_no_edge_stable: assert property (@(posedge clk) disable iff (rst)
        !shift_edge |=> $stable(word_ff))
        else $error("word changed without a shift clock edge");

    a_clear_first: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && !pins_s.sync_clear_n) |=> (word_ff == 8'h00))
        else $error("clear at edge did not zero the word");

    a_load_pins: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && pins_s.sync_clear_n && !clear_pend_ff && mode == USR_MODE_LOAD)
        |=> (word_ff == $past(pins_s.pins)))
        else $error("load did not take the pin values");

    a_shift_right: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && pins_s.sync_clear_n && !clear_pend_ff && mode == USR_MODE_RIGHT)
        |=> (word_ff == {$past(word_ff[6:0]), $past(pins_s.right_shift_serial_in)}))
        else $error("right shift moved the wrong bits");

    a_shift_left: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && pins_s.sync_clear_n && !clear_pend_ff && mode == USR_MODE_LEFT)
        |=> (word_ff == {$past(pins_s.left_shift_serial_in), $past(word_ff[7:1])}))
        else $error("left shift moved the wrong bits");

    a_hold_word: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && pins_s.sync_clear_n && !clear_pend_ff && mode == USR_MODE_HOLD)
        |=> $stable(word_ff))
        else $error("hold mode changed the word");

    // checks on the pin drivers
    a_float_enable: assert property (@(posedge clk) disable iff (rst)
        (pins_s.bus_drive_en_a_n || pins_s.bus_drive_en_b_n)
        |=> (shared_parallel_pins_oe == 8'h00))
        else $error("pins driven while an enable is high");

    a_float_load: assert property (@(posedge clk) disable iff (rst)
        (mode == USR_MODE_LOAD) |=> (shared_parallel_pins_oe == 8'h00))
        else $error("pins driven in load mode");

    a_drive_on: assert property (@(posedge clk) disable iff (rst)
        (!pins_s.bus_drive_en_a_n && !pins_s.bus_drive_en_b_n && mode != USR_MODE_LOAD)
        |=> (shared_parallel_pins_oe == 8'hFF))
        else $error("pins not driven although enabled");
    a_float_shifts: assert property (@(posedge clk) disable iff (rst)
        (shift_edge && pins_s.bus_drive_en_a_n && pins_s.sync_clear_n && !clear_pend_ff
         && mode == USR_MODE_RIGHT) |=> (word_ff[0] == $past(pins_s.right_shift_serial_in)))
        else $error("floated pins stopped a shift");
    a_serial_ends: assert property (@(posedge clk) disable iff (rst)
        shift_edge |=> (first_stage_serial_out == $past(nxt_word[0])
                        && last_stage_serial_out == $past(nxt_word[7])))
        else $error("serial outputs do not follow the end stages");

endmodule

`default_nettype wire

// >>> bench/usr_board_model.sv
// board-side model: resolves the shared parallel pins of the block
// assumes the bench supplies board drive data and enable, the dut its pin outputs
`timescale 1ns/1ps
`default_nettype none

module usr_board_model (
    input  wire logic       clk,
    input  wire logic [7:0] dev_out,
    input  wire logic [7:0] dev_oe,
    input  wire logic [7:0] drv_data,
    input  wire logic       drv_en,
    output logic      [7:0] pins,
    output logic            clash
);
    logic [7:0] float_ff = 8'hA5;
    logic       clash_ff = 1'b0;

    // undriven lines wander each cycle so a stale value never passes for data
    always_ff @(posedge clk) float_ff <= {float_ff[6:0], ~float_ff[7]};

    // sticky flag: board drove while the device was driving
    always_ff @(posedge clk) if (drv_en && |dev_oe) clash_ff <= 1'b1;
    assign clash = clash_ff;

    // device wins where it drives, then the board, then the wandering float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins[i] = dev_oe[i] ? dev_out[i] : (drv_en ? drv_data[i] : float_ff[i]);
        end
    end
endmodule
`default_nettype wire

// >>> bench/universal_shift_register_8bit_tb.sv
// self-checking bench for the shift register block and its lite bus
// assumes usr_board_model resolves the shared pins between board and dut
`timescale 1ns/1ps
`default_nettype none
`include "usr_params.svh"

module universal_shift_register_8bit_tb
    import usr_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst, sclk, clr_n, s_hi, s_lo, rsi, lsi, en_a_n, en_b_n, drv_en, clash;
    logic [7:0]  drv_data, pins, p_out, p_oe, word_exp;
    logic        q_first, q_last, pend_exp;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    int          n_fail = 0, comparisons = 0, cycles = 0, edges_exp = 0;

    usr_shift_top dut (
        .clk(clk), .rst(rst), .shift_clock(sclk), .sync_clear_n(clr_n),
        .mode_select_hi(s_hi), .mode_select_lo(s_lo), .right_shift_serial_in(rsi),
        .left_shift_serial_in(lsi), .bus_drive_en_a_n(en_a_n), .bus_drive_en_b_n(en_b_n),
        .shared_parallel_pins_in(pins), .shared_parallel_pins_out(p_out),
        .shared_parallel_pins_oe(p_oe), .first_stage_serial_out(q_first),
        .last_stage_serial_out(q_last), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    usr_board_model board (.clk(clk), .dev_out(p_out), .dev_oe(p_oe), .drv_data(drv_data),
        .drv_en(drv_en), .pins(pins), .clash(clash));

    // 200 MHz system clock
    always #2.5 clk = ~clk;

    // watchdog: a hung handshake ends the run as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // expected word after one shift edge
    function automatic logic [7:0] next_word(input logic [7:0] w, input logic [1:0] m,
        input logic c, input logic [7:0] d, input logic sr, input logic sl);
        if (!c) return 8'h00;
        case (m)
            2'h0: return w;
            2'h1: return {w[6:0], sr};
            2'h2: return {sl, w[7:1]};
            default: return d;
        endcase
    endfunction

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // one shift-clock pulse; inputs stay steady well around the edge (sync delay)
    task automatic shift_pulse(input logic [1:0] m, input logic c, input logic [7:0] d,
                               input logic sr, input logic sl, input logic [1:0] en);
        logic oe;
        oe = (en == 2'b00) && (m != 2'h3);
        clr_n <= c;
        {s_hi, s_lo} <= m;
        rsi <= sr;
        lsi <= sl;
        {en_a_n, en_b_n} <= en;
        drv_data <= d;
        repeat (5) @(posedge clk);
        drv_en <= (m == 2'h3);
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        word_exp = pend_exp ? 8'h00 : next_word(word_exp, m, c, d, sr, sl);
        pend_exp = 1'b0;
        edges_exp++;
        repeat (5) @(posedge clk);
        check(p_out, word_exp);
        sclk <= 1'b0;
        repeat (5) @(posedge clk);
        check(p_out, word_exp);
        check({q_last, q_first}, {word_exp[7], word_exp[0]});
        check(p_oe, {8{oe}});
        if (oe) check(pins, word_exp);
        axi_read(`USR_OFF_STATUS, rd, resp);
        check(rd & 32'hFFF, {20'h0, 1'b0, oe, m, word_exp});
        drv_en <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        {sclk, s_hi, s_lo, rsi, lsi, drv_en} = '0;
        {clr_n, en_a_n, en_b_n} = '1;
        drv_data = 8'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        word_exp = 8'h00;
        pend_exp = 1'b0;
        void'($urandom(60004));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(p_oe, 8'h00);
        repeat (2) @(posedge clk);
        // register reset values, read-only status, unmapped place
        axi_read(`USR_OFF_CTRL, rd, resp);
        check(rd, 32'h2);
        axi_write(`USR_OFF_STATUS, 32'hFFFF_FFFF, resp);
        check(resp, `USR_RESP_OKAY);
        axi_read(`USR_OFF_STATUS, rd, resp);
        check(rd, 32'h0);
        axi_read(4'hC, rd, resp);
        check(rd, 32'h0);
        check(resp, `USR_RESP_SLVERR);
        axi_write(4'hC, 32'h1, resp);
        check(resp, `USR_RESP_SLVERR);
        // fill with ones, then every mode at its corners
        for (int i = 0; i < 8; i++) shift_pulse(2'h1, 1'b1, 8'h00, 1'b1, 1'b0, 2'b00);
        shift_pulse(2'h2, 1'b1, 8'h00, 1'b0, 1'b0, 2'b01);
        shift_pulse(2'h3, 1'b1, 8'h5A, 1'b0, 1'b0, 2'b00);
        shift_pulse(2'h0, 1'b1, 8'h00, 1'b1, 1'b1, 2'b10);
        shift_pulse(2'h3, 1'b0, 8'hC3, 1'b1, 1'b1, 2'b00);
        shift_pulse(2'h3, 1'b1, 8'hA5, 1'b0, 1'b0, 2'b11);
        // software clear waits for the next shift edge and beats the mode
        axi_write(`USR_OFF_CTRL, 32'h3, resp);
        pend_exp = 1'b1;
        axi_read(`USR_OFF_STATUS, rd, resp);
        check(rd[11], 1'b1);
        shift_pulse(2'h1, 1'b1, 8'h00, 1'b1, 1'b0, 2'b00);
        repeat (40) shift_pulse(2'($urandom), ($urandom % 8) != 0, 8'($urandom),
                                1'($urandom), 1'($urandom), 2'($urandom));
        // edge counter counts every shift edge, any write zeroes it
        axi_read(`USR_OFF_EDGES, rd, resp);
        check(rd, edges_exp);
        axi_write(`USR_OFF_EDGES, 32'h0, resp);
        axi_read(`USR_OFF_EDGES, rd, resp);
        check(rd, 32'h0);
        // lane 0 masked keeps counting on; counting off then leaves the count alone
        wstrb <= 4'hE;
        axi_write(`USR_OFF_CTRL, 32'h0, resp);
        wstrb <= 4'hF;
        axi_read(`USR_OFF_CTRL, rd, resp);
        check(rd, 32'h2);
        axi_write(`USR_OFF_CTRL, 32'h0, resp);
        shift_pulse(2'h0, 1'b1, 8'h00, 1'b0, 1'b0, 2'b11);
        axi_read(`USR_OFF_EDGES, rd, resp);
        check(rd, 32'h0);
        check(clash, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
